// ==== dtb_ctl_model.sv ====
// Controller model: both clock pairs, commands and write beats.
// Assumes one call per K cycle; clocks stand still between calls.
`timescale 1ns/1ps
`default_nettype none
module dtb_ctl_model (
	input wire logic tie_in,
	output logic kclk_out,
	output logic kclk_n_out,
	output logic cclk_out,
	output logic cclk_n_out,
	output logic load_n_out,
	output logic rnw_out,
	output logic [19:0] addr_out,
	output logic [35:0] wdata_out,
	output logic [3:0] we_n_out
);
	event s0;
	event s1;
	// Parking output clocks high moves read timing onto K
	assign cclk_out = tie_in | kclk_out;
	assign cclk_n_out = tie_in | kclk_n_out;
	// All clocks rest low together; first cycle is already clean
	initial begin
		kclk_out = 1'b0;
		kclk_n_out = 1'b0;
		load_n_out = 1'b1;
		rnw_out = 1'b0;
		addr_out = 20'h0;
		wdata_out = 36'h0;
		we_n_out = 4'hf;
	end
	// Pins change mid-way between clock edges for equal setup and hold
	task automatic cyc(input logic ld, input logic rw, input logic [19:0] a,
		input logic [35:0] d0, input logic [3:0] w0, input logic [35:0] d1, input logic [3:0] w1);
		load_n_out = ld;
		rnw_out = rw;
		addr_out = a;
		wdata_out = d0;
		we_n_out = w0;
		#80 kclk_out = 1'b1;
		kclk_n_out = 1'b0;
		#80 wdata_out = d1;
		we_n_out = w1;
		->s0;
		#80 kclk_out = 1'b0;
		kclk_n_out = 1'b1;
		// Check event one step early, before the next call shifts the bench's expectations
		#79 ->s1;
		#1;
	endtask
endmodule // dtb_ctl_model
`default_nettype wire

// ==== dtb_edge_sync.sv ====
// Two-flop synchroniser with rising-edge pulse for one pin-side clock.
// Assumes core_clk_in is several times faster than the sampled clock.
`timescale 1ns/1ps
`default_nettype none
module dtb_edge_sync (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out
);
	logic meta_r;
	logic sync_r;
	logic last_r;
	// First flop feeds only the second
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end
	assign level_out = sync_r;
	assign rise_out = sync_r & ~last_r;
endmodule // dtb_edge_sync
`default_nettype wire

// ==== dtb_pkg.sv ====
// Types shared by the memory port design.
// Assumes dtb_regs.svh is on the include path.
`include "dtb_regs.svh"
package dtb_pkg;
	typedef enum logic [1:0] {
		DTB_IDLE = 2'b00,
		DTB_WR_B1 = 2'b01,
		DTB_RD_B1 = 2'b11
	} dtb_state_e;
	typedef logic [1:0] dtb_org_t;
endpackage

// ==== dtb_port.sv ====
// Device side of a separate-I/O double-rate static RAM port, two-word burst.
// Assumes all pins are asynchronous to core_clk_in and clocks run well below it.
`timescale 1ns/1ps
`default_nettype none
`include "dtb_regs.svh"
module dtb_port
	import dtb_pkg::*;
#(
	parameter int ADDR_W = `DTB_ADDR_W,
	parameter int MEM_WORDS = `DTB_MEM_WORDS,
	parameter logic [1:0] ORG = `DTB_ORG_X36
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic kclk_in,
	input wire logic kclk_n_in,
	input wire logic cclk_in,
	input wire logic cclk_n_in,
	input wire logic load_strobe_n_in,
	input wire logic read_not_write_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [`DTB_DATA_W-1:0] wdata_in,
	input wire logic nibble_write_n0_in,
	input wire logic nibble_write_n1_in,
	input wire logic lane_write_n0_in,
	input wire logic lane_write_n1_in,
	input wire logic lane_write_n2_in,
	input wire logic lane_write_n3_in,
	output logic [`DTB_DATA_W-1:0] rdata_out,
	output logic rdata_oe_out,
	output logic echo_clock_true_out,
	output logic echo_clock_comp_out
);
	localparam int IDX_W = $clog2(MEM_WORDS);
	localparam int PIN_W = ADDR_W + `DTB_DATA_W + 8;
	localparam int DW = `DTB_DATA_W;

	// Per-bit write mask from the enables of the selected organisation
	function automatic logic [DW-1:0] lane_mask(input logic [1:0] org, input logic [3:0] bw_n,
		input logic [1:0] nw_n);
		logic [DW-1:0] m;
		m = '0;
		case (org)
			`DTB_ORG_X8: begin
				m[3:0] = {4{~nw_n[0]}};
				m[7:4] = {4{~nw_n[1]}};
			end
			`DTB_ORG_X9: m[8:0] = {9{~bw_n[0]}};
			`DTB_ORG_X18: begin
				m[8:0] = {9{~bw_n[0]}};
				m[17:9] = {9{~bw_n[1]}};
			end
			default: begin
				for (int i = 0; i < `DTB_LANES; i++) begin
					m[i*`DTB_LANE_W +: `DTB_LANE_W] = {`DTB_LANE_W{~bw_n[i]}};
				end
			end
		endcase
		return m;
	endfunction

	// Data pins pass two flops; they are sampled a cycle after the clock edge is seen,
	// so setup and hold around the pin edge map onto a stable synchronised value.
	logic [PIN_W-1:0] pin_meta_r;
	logic [PIN_W-1:0] pin_sync_r;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_meta_r <= '0;
			pin_sync_r <= {PIN_W{1'b1}};
		end else begin
			pin_meta_r <= {addr_in, wdata_in, load_strobe_n_in, read_not_write_in,
				nibble_write_n1_in, nibble_write_n0_in, lane_write_n3_in,
				lane_write_n2_in, lane_write_n1_in, lane_write_n0_in};
			pin_sync_r <= pin_meta_r;
		end
	end

	// Unpack synchronised pin bundle
	wire logic [ADDR_W-1:0] s_addr = pin_sync_r[PIN_W-1 -: ADDR_W];
	wire logic [DW-1:0] s_wdata = pin_sync_r[DW+7:8];
	wire logic s_load_n = pin_sync_r[7];
	wire logic s_rnw = pin_sync_r[6];
	wire logic [1:0] s_nw_n = pin_sync_r[5:4];
	wire logic [3:0] s_bw_n = pin_sync_r[3:0];

	// Clock pins, synchronised and edge detected
	logic k_lvl;
	logic k_rise;
	logic kn_lvl;
	logic kn_rise;
	logic c_lvl;
	logic c_rise;
	logic cn_lvl;
	logic cn_rise;
	dtb_edge_sync u_k (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .pin_in(kclk_in),
		.level_out(k_lvl), .rise_out(k_rise));
	dtb_edge_sync u_kn (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .pin_in(kclk_n_in),
		.level_out(kn_lvl), .rise_out(kn_rise));
	dtb_edge_sync u_c (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .pin_in(cclk_in),
		.level_out(c_lvl), .rise_out(c_rise));
	dtb_edge_sync u_cn (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .pin_in(cclk_n_in),
		.level_out(cn_lvl), .rise_out(cn_rise));

	// Delay edges one cycle so the data bundle, two flops deep, lines up
	logic k_ev_r;
	logic kn_ev_r;
	logic c_ev_r;
	logic cn_ev_r;
	logic c_tied_r;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			k_ev_r <= 1'b0;
			kn_ev_r <= 1'b0;
			c_ev_r <= 1'b0;
			cn_ev_r <= 1'b0;
			c_tied_r <= 1'b0;
		end else begin
			k_ev_r <= k_rise;
			kn_ev_r <= kn_rise;
			c_ev_r <= c_rise;
			cn_ev_r <= cn_rise;
			// Tied-high output clocks show no edge over a K period while high
			c_tied_r <= c_lvl & cn_lvl & (k_rise ? 1'b1 : c_tied_r) & ~c_rise & ~cn_rise;
		end
	end

	// Output timing clock selection
	wire logic out_true_ev = c_tied_r ? k_ev_r : c_ev_r;
	wire logic out_comp_ev = c_tied_r ? kn_ev_r : cn_ev_r;

	// Command decode only at the true input clock rise
	wire logic cmd_take = k_ev_r & ~s_load_n;
	wire logic cmd_write = cmd_take & ~s_rnw;
	wire logic cmd_read = cmd_take & s_rnw;
	wire logic [DW-1:0] beat_mask = lane_mask(ORG, s_bw_n, s_nw_n);

	// Memory array, kept small; upper address bits beyond IDX_W are ignored
	logic [DW-1:0] mem_r [MEM_WORDS];
	logic [IDX_W-1:0] wr_idx_r;
	logic [IDX_W-1:0] rd_idx_r;
	logic wr_b0_pend_r;
	logic wr_b1_pend_r;
	logic rd_b0_pend_r;
	logic rd_b1_pend_r;
	logic [DW-1:0] rd_next_r;

	// Write burst: beat A+0 on next K rise, A+1 on following K# rise
	wire logic wr_b0_go = wr_b0_pend_r & k_ev_r;
	wire logic wr_b1_go = wr_b1_pend_r & kn_ev_r;
	// Beat A+1 keeps its own index, since a back-to-back write reloads wr_idx_r first
	logic [IDX_W-1:0] wr_b1_idx_r;
	always_ff @(posedge core_clk_in) begin
		if (wr_b0_go) begin
			mem_r[wr_idx_r] <= (mem_r[wr_idx_r] & ~beat_mask) | (s_wdata & beat_mask);
		end
		if (wr_b1_go) begin
			mem_r[wr_b1_idx_r] <= (mem_r[wr_b1_idx_r] & ~beat_mask) | (s_wdata & beat_mask);
		end
	end

	// Write sequencing; a new command at the same K edge reloads the address
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_idx_r <= '0;
			wr_b1_idx_r <= '0;
			wr_b0_pend_r <= 1'b0;
			wr_b1_pend_r <= 1'b0;
		end else begin
			if (wr_b1_go) begin
				wr_b1_pend_r <= 1'b0;
			end
			if (wr_b0_go) begin
				wr_b0_pend_r <= 1'b0;
				wr_b1_pend_r <= 1'b1;
				wr_b1_idx_r <= wr_idx_r ^ IDX_W'(1);
			end
			if (cmd_write) begin
				wr_idx_r <= s_addr[IDX_W-1:0];
				wr_b0_pend_r <= 1'b1;
			end
		end
	end

	// Read state: command at K(t), A+0 at C#(t+1), A+1 at C(t+2)
	dtb_state_e rd_st_r;
	logic rd_arm_r;
	logic [IDX_W-1:0] rd_q_idx_r;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_st_r <= DTB_IDLE;
			rd_idx_r <= '0;
			rd_q_idx_r <= '0;
			rd_arm_r <= 1'b0;
			rd_b0_pend_r <= 1'b0;
			rd_b1_pend_r <= 1'b0;
		end else begin
			// Address waits one K cycle, so a back-to-back read cannot overwrite it
			if (cmd_read) begin
				rd_q_idx_r <= s_addr[IDX_W-1:0];
			end
			if (k_ev_r) begin
				rd_arm_r <= cmd_read;
			end
			// Beat A+0 falls due at the K rise of cycle t+1, then waits for C#
			if (k_ev_r & rd_arm_r) begin
				rd_idx_r <= rd_q_idx_r;
				rd_b0_pend_r <= 1'b1;
			end
			case (rd_st_r)
				DTB_IDLE: begin
					if (out_comp_ev & rd_b0_pend_r) begin
						rd_st_r <= DTB_RD_B1;
						rd_b0_pend_r <= 1'b0;
						rd_b1_pend_r <= 1'b1;
					end
				end
				DTB_RD_B1: begin
					if (out_true_ev) begin
						rd_b1_pend_r <= 1'b0;
						rd_st_r <= (out_comp_ev & rd_b0_pend_r) ? DTB_RD_B1 : DTB_WR_B1;
					end
				end
				DTB_WR_B1: begin
					// Beat A+1 shown until next C# rise, then a pending A+0 or tristate
					if (out_comp_ev) begin
						rd_st_r <= rd_b0_pend_r ? DTB_RD_B1 : DTB_IDLE;
						rd_b0_pend_r <= 1'b0;
						rd_b1_pend_r <= rd_b0_pend_r;
					end
				end
				default: rd_st_r <= DTB_IDLE;
			endcase
		end
	end

	// Read data registers; outputs tristated outside a read burst
	wire logic rd_b0_fire = out_comp_ev & rd_b0_pend_r;
	wire logic rd_b1_fire = out_true_ev & rd_b1_pend_r & (rd_st_r == DTB_RD_B1);
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= '0;
			rdata_oe_out <= 1'b0;
			rd_next_r <= '0;
		end else begin
			if (rd_b0_fire) begin
				rdata_out <= mem_r[rd_idx_r];
				rd_next_r <= mem_r[rd_idx_r ^ IDX_W'(1)];
				rdata_oe_out <= 1'b1;
			end else if (rd_b1_fire) begin
				rdata_out <= rd_next_r;
			end else if (out_comp_ev && rd_st_r != DTB_RD_B1) begin
				rdata_oe_out <= 1'b0;
			end
		end
	end

	// Echo clocks follow the selected output clock pair, even while data tristates
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			echo_clock_true_out <= 1'b0;
			echo_clock_comp_out <= 1'b0;
		end else begin
			echo_clock_true_out <= c_tied_r ? k_lvl : c_lvl;
			echo_clock_comp_out <= c_tied_r ? kn_lvl : cn_lvl;
		end
	end
endmodule // dtb_port
`default_nettype wire

// ==== dtb_port_asserts.sv ====
// Pin-level checks for the memory port.
// Assumes a bind to dtb_port; pins move between core edges.
`timescale 1ns/1ps
`default_nettype none
`include "dtb_regs.svh"
module dtb_port_asserts (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic kclk_in,
	input wire logic cclk_in,
	input wire logic cclk_n_in,
	input wire logic load_strobe_n_in,
	input wire logic read_not_write_in,
	input wire logic [`DTB_DATA_W-1:0] rdata_out,
	input wire logic rdata_oe_out,
	input wire logic echo_clock_true_out,
	input wire logic echo_clock_comp_out
);
	logic [5:0] rd_r, cn_r, tie_r, rd_nxt, cn_nxt, tie_nxt;
	logic seen_r, cq_r, kq_r;
	// Ages saturate, so a long idle never wraps into a false match; each read restarts
	// the age at its own K rise, so the first of back-to-back reads is aged from the second read's command
	assign rd_nxt = (kclk_in && !kq_r && !load_strobe_n_in && read_not_write_in) ? 6'h0 :
		rd_r + 6'(rd_r != 6'h3f);
	assign cn_nxt = (cclk_n_in && !cq_r) ? 6'h0 : cn_r + 6'(cn_r != 6'h3f);
	assign tie_nxt = (cclk_in && cclk_n_in) ? tie_r + 6'(tie_r != 6'h3f) : 6'h0;
	// Helper ages and flags
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_r <= 6'h3f;
			cn_r <= 6'h3f;
			tie_r <= 6'h0;
			seen_r <= 1'b0;
			cq_r <= 1'b0;
			kq_r <= 1'b0;
		end else begin
			rd_r <= rd_nxt;
			cn_r <= cn_nxt;
			tie_r <= tie_nxt;
			seen_r <= seen_r | (rd_nxt == 6'h0);
			cq_r <= cclk_n_in;
			kq_r <= kclk_in;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	a_oe_needs_read: assert property (!seen_r |-> !rdata_oe_out)
		else $error("oe before any read");
	a_oe_read_age: assert property ($rose(rdata_oe_out) |-> rd_r inside {[6:16]})
		else $error("oe not tied to a read");
	a_oe_min_width: assert property ($rose(rdata_oe_out) |-> rdata_oe_out[*8])
		else $error("read window short");
	a_beat0_holds: assert property ($rose(rdata_oe_out) |=> $stable(rdata_out)[*3])
		else $error("first beat moved early");
	a_oe_drop_c: assert property ($fell(rdata_oe_out) && !(cclk_in && cclk_n_in)
		|-> cn_r inside {[2:5]}) else $error("oe drop off output clock");
	a_echo_true: assert property ($rose(cclk_in) && !cclk_n_in |-> ##[1:5] echo_clock_true_out)
		else $error("echo true missed");
	a_echo_comp: assert property ($rose(cclk_n_in) && !cclk_in |-> ##[1:5] echo_clock_comp_out)
		else $error("echo comp missed");
	a_tie_echo_k: assert property (tie_r > 6'd8 && $fell(kclk_in)
		|-> ##[1:5] !echo_clock_true_out) else $error("echo not on input clock");
	c_read: cover property ($rose(rdata_oe_out));
	c_tie_read: cover property (tie_r > 6'd8 && $rose(rdata_oe_out));
	c_write: cover property (!load_strobe_n_in && !read_not_write_in);
endmodule // dtb_port_asserts
`default_nettype wire

// ==== dtb_regs.svh ====
// Constants for the two-word burst double-rate memory port.
// Included by the package, the port and its assertions; definitions only.
`ifndef DTB_REGS_SVH
`define DTB_REGS_SVH
`define DTB_ADDR_W 20
`define DTB_DATA_W 36
`define DTB_LANES 4
`define DTB_LANE_W 9
`define DTB_ORG_X8 2'h0
`define DTB_ORG_X9 2'h1
`define DTB_ORG_X18 2'h2
`define DTB_ORG_X36 2'h3
`define DTB_MEM_WORDS 256
`endif

// ==== tb.sv ====
// Testbench: four organisations side by side against a local memory model.
// Assumes the controller model drives every pin, 13 ns after core edges.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic tie = 1'b0;
	logic kc, kcn, cc, ccn, ldn, rnw;
	logic [19:0] addr;
	logic [35:0] wd, pb0, pb1;
	logic [3:0] wen, pw0, pw1;
	logic [35:0] rd [4];
	logic oe [4];
	logic [35:0] mem [4][16];
	logic [35:0] pe0 [3][4];
	logic [35:0] pe1 [3][4];
	logic pv [3];
	logic [31:0] seed = 32'h8dae;
	logic [31:0] r;
	int miscompares = 0;
	int checks = 0;
	int ticks = 0;
	initial forever #20 clk = ~clk;
	for (genvar g = 0; g < 4; g++) begin : gen_org
		dtb_port #(.ORG(2'(g))) dtb_port_i (.core_clk_in(clk), .nrst_in(nrst),
			.kclk_in(kc), .kclk_n_in(kcn), .cclk_in(cc), .cclk_n_in(ccn),
			.load_strobe_n_in(ldn), .read_not_write_in(rnw), .addr_in(addr), .wdata_in(wd),
			.nibble_write_n0_in(wen[0]), .nibble_write_n1_in(wen[1]),
			.lane_write_n0_in(wen[0]), .lane_write_n1_in(wen[1]),
			.lane_write_n2_in(wen[2]), .lane_write_n3_in(wen[3]),
			.rdata_out(rd[g]), .rdata_oe_out(oe[g]),
			.echo_clock_true_out(), .echo_clock_comp_out());
	end
	dtb_ctl_model dtb_ctl_model_i (.tie_in(tie), .kclk_out(kc), .kclk_n_out(kcn),
		.cclk_out(cc), .cclk_n_out(ccn), .load_n_out(ldn), .rnw_out(rnw),
		.addr_out(addr), .wdata_out(wd), .we_n_out(wen));
	function logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// Bits that enable pattern w lets through in organisation o
	function automatic logic [35:0] om(input int o, input logic [3:0] w);
		case (o)
			0: return {28'h0, {4{~w[1]}}, {4{~w[0]}}};
			1: return {27'h0, {9{~w[0]}}};
			2: return {18'h0, {9{~w[1]}}, {9{~w[0]}}};
			default: return {{9{~w[3]}}, {9{~w[2]}}, {9{~w[1]}}, {9{~w[0]}}};
		endcase
	endfunction
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One K cycle; a read's beats are due two cycles later
	task automatic op(input logic ld, input logic rw, input logic [3:0] a,
		input logic [3:0] w0, input logic [3:0] w1);
		logic [35:0] d0, d1;
		d0 = 36'({rnd(), rnd()});
		d1 = 36'({rnd(), rnd()});
		pv[2] = pv[1];
		pv[1] = pv[0];
		pv[0] = !ld && rw;
		pe0[2] = pe0[1];
		pe0[1] = pe0[0];
		pe1[2] = pe1[1];
		pe1[1] = pe1[0];
		for (int o = 0; o < 4; o++) begin
			pe0[0][o] = pv[0] ? mem[o][a] & om(o, 4'h0) : 36'h0;
			pe1[0][o] = pv[0] ? mem[o][a ^ 4'h1] & om(o, 4'h0) : 36'h0;
			if (!ld && !rw) begin
				mem[o][a] = mem[o][a] & ~om(o, w0) | d0 & om(o, w0);
				mem[o][a ^ 4'h1] = mem[o][a ^ 4'h1] & ~om(o, w1) | d1 & om(o, w1);
			end
		end
		dtb_ctl_model_i.cyc(ld, rw, {16'h0, a}, pb0, pw0, pb1, pw1);
		pb0 = d0;
		pw0 = w0;
		pb1 = d1;
		pw1 = w1;
	endtask
	// Beats are looked at mid-window; no read due means outputs off
	// Expected beats count only when a read is due; the history starts unknown
	always @(dtb_ctl_model_i.s0) for (int o = 0; o < 4; o++)
		chk({3'h0, oe[o], pv[2] ? rd[o] & om(o, 4'h0) : 36'h0},
			{3'h0, pv[2], pv[2] ? pe0[2][o] : 36'h0});
	always @(dtb_ctl_model_i.s1) for (int o = 0; o < 4; o++)
		chk({3'h0, oe[o], pv[2] ? rd[o] & om(o, 4'h0) : 36'h0},
			{3'h0, pv[2], pv[2] ? pe1[2][o] : 36'h0});
	always @(posedge clk) begin
		ticks++;
		if (ticks == 4000) begin
			miscompares++;
			print_verdict();
		end
	end
	// Fill, then random pairs; when both ops of a pair read, reads run back to back
	initial begin
		pv = '{1'b0, 1'b0, 1'b0};
		repeat (6) @(posedge clk);
		#13 nrst = 1'b1;
		repeat (4) @(posedge clk);
		#13;
		for (int a = 0; a < 16; a++) op(1'b0, 1'b0, 4'(a), 4'h0, 4'h0);
		$display("test fill done");
		for (int ph = 0; ph < 3; ph++) begin
			tie = (ph == 2);
			for (int i = 0; i < 40; i++) begin
				r = rnd();
				op(r[0] & r[25], r[0], {ph[0], r[3:1]}, r[7:4], r[11:8]);
				op(r[12] & r[13], 1'b1, {~ph[0], r[16:14]}, r[20:17], r[24:21]);
			end
			repeat (2) op(1'b1, 1'b0, 4'h0, 4'h0, 4'h0);
			$display("test phase %0d done", ph);
		end
		print_verdict();
	end
endmodule // tb
bind dtb_port dtb_port_asserts dtb_port_asserts_i (.core_clk_in(core_clk_in),
	.nrst_in(nrst_in), .kclk_in(kclk_in), .cclk_in(cclk_in), .cclk_n_in(cclk_n_in),
	.load_strobe_n_in(load_strobe_n_in), .read_not_write_in(read_not_write_in),
	.rdata_out(rdata_out), .rdata_oe_out(rdata_oe_out),
	.echo_clock_true_out(echo_clock_true_out), .echo_clock_comp_out(echo_clock_comp_out));
`default_nettype wire
